//--- tbea_pkg.sv
package tbea_pkg;

  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ZONE_CFG = 8'h04;
  localparam logic [7:0] OFF_LIGHT_EN = 8'h08;
  localparam logic [7:0] OFF_PRES_EN = 8'h0c;
  localparam logic [7:0] OFF_EV_ON_SEL = 8'h10;
  localparam logic [7:0] OFF_EV_OFF_SEL = 8'h14;
  localparam logic [7:0] OFF_PROT_COND = 8'h18;
  localparam logic [7:0] OFF_SENSOR_STAT = 8'h1c;
  localparam logic [7:0] OFF_COMMON_COND = 8'h20;
  localparam logic [7:0] OFF_PROT_COUNT = 8'h24;
  localparam logic [7:0] OFF_COMMON_COUNT = 8'h28;
  localparam logic [7:0] OFF_REC_SEL = 8'h2c;
  localparam logic [7:0] OFF_REC_STAT = 8'h30;
  localparam logic [7:0] OFF_REC_STAMP_LO = 8'h34;
  localparam logic [7:0] OFF_REC_STAMP_HI = 8'h38;
  localparam logic [7:0] OFF_REC_INFO = 8'h3c;
  localparam logic [7:0] OFF_REC_CUR_AB = 8'h40;
  localparam logic [7:0] OFF_REC_CUR_CR = 8'h44;

  // Control register fields
  localparam int CTRL_FORCE_EN = 0;
  localparam int CTRL_FORCE_SEL = 1;
  localparam int CTRL_CLR_PROT = 8;
  localparam int CTRL_CLR_START = 9;
  localparam int CTRL_CLR_TRIP = 10;

  // Zone configuration fields
  localparam int ZCFG_ENABLE = 0;
  localparam int ZCFG_PH_EN = 4;
  localparam int ZCFG_RES_EN = 8;
  localparam int ZCFG_DI_MODE = 12;

  // Event flag positions
  localparam int EV_ZONE_TRIP = 0;
  localparam int EV_ZONE_BLK = 4;
  localparam int EV_PH_BLK = 8;
  localparam int EV_PH_START = 9;
  localparam int EV_RES_BLK = 10;
  localparam int EV_RES_START = 11;
  localparam int EV_LIGHT = 12;
  localparam int EV_PRES = 16;
  localparam int EV_DI = 20;
  localparam int EV_SENS_FAULT = 21;
  localparam int EV_IO_FAULT = 25;
  localparam int EV_COM_START = 26;
  localparam int EV_COM_TRIP = 27;
  localparam int NUM_PROT_EV = 26;
  localparam int NUM_EV = 28;

  // Widths and reset values
  localparam int TS_W = 48;
  localparam int CUR_W = 16;
  localparam int CNT_W = 16;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;

  typedef enum logic [1:0] {
    DI_OFF = 2'h0,
    DI_LIGHT_IN = 2'h1,
    DI_CURRENT_IN = 2'h2
  } di_mode_t;

  typedef enum logic [1:0] {
    COND_NORMAL = 2'h0,
    COND_START = 2'h1,
    COND_TRIP = 2'h2
  } cond_t;

endpackage : tbea_pkg

//--- trip_block_event_aggregator.sv
// The implementer's own choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/10ps
// Functional notes
// - Blocking input is sampled once per program cycle, at the tick.
// - Pick-up rising with blocking inactive asserts the zone trip output.
// - Pick-up rising with blocking active asserts blocked, not trip, and holds.
// - Readable condition word has trip and blocked flags for four zones.
// - Readable sensor status: current start/blocked, light, pressure, input, faults.
// - Each status flag emits ON on rising and OFF on falling edges.
// - Per-event select of ON, OFF or both; unselected edges are not stored.
// - Every stored event carries the time stamp of its tick.
// - Protection event counter counts its events and clears by command.
// - Twelve most recent operation records kept circularly, oldest overwritten.
// - Record holds time, event, four trip currents, sensors, setting group.
// - Common START and TRIP are the OR of all function starts and trips; here START stays low while TRIP is active.
// - Extra assignable inputs also feed common START and TRIP.
// - Force setting start/trip overrides status only while forcing enabled; force normal leaves it unchanged.
// - Aggregator settings are static, independent of the setting group.
// - Readable aggregator condition shows normal, start or trip.
// - The aggregator has no blocking input of its own.
// - Common START/TRIP emit ON/OFF events and have clearable counters.
// - Outside current-in input mode, a light or pressure channel trips a zone only when enabled for it.
// - Current-in input mode trips only together with an active sensor channel.
module trip_block_event_aggregator
  import tbea_pkg::*;
#(
  parameter int NUM_PROT = 8,
  parameter int REC_DEPTH = 12
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic cycleTick,
  input wire logic [TS_W-1:0] timeStamp,
  input wire logic blockIn,
  input wire logic phCurrPickup,
  input wire logic resCurrPickup,
  input wire logic [3:0] lightIn,
  input wire logic [3:0] pressureIn,
  input wire logic digitalIn,
  input wire logic [3:0] sensorFault,
  input wire logic ioUnitFault,
  input wire logic [CUR_W-1:0] phaseCurrA,
  input wire logic [CUR_W-1:0] phaseCurrB,
  input wire logic [CUR_W-1:0] phaseCurrC,
  input wire logic [CUR_W-1:0] residualCurr,
  input wire logic [2:0] settingGroup,
  input wire logic [NUM_PROT-1:0] protStart,
  input wire logic [NUM_PROT-1:0] protTrip,
  input wire logic commonStartIn,
  input wire logic commonTripIn,
  output logic [3:0] zoneTrip,
  output logic [3:0] zoneBlocked,
  output logic commonStart,
  output logic commonTrip,
  output logic eventStrobe,
  output logic [NUM_EV-1:0] eventOn,
  output logic [NUM_EV-1:0] eventOff,
  output logic [TS_W-1:0] eventStamp
);

  // Fill level and index are four bits wide; deeper stores would need wider counters
  if (REC_DEPTH < 2 || REC_DEPTH > 15) begin : g_bad_depth
    $error("REC_DEPTH must be 2 to 15");
  end
  if (NUM_PROT < 1 || NUM_PROT > 32) begin : g_bad_prot
    $error("NUM_PROT must be 1 to 32");
  end

  localparam logic [3:0] LAST_SLOT = 4'(REC_DEPTH - 1);
  localparam logic [3:0] DEPTH4 = 4'(REC_DEPTH);

  // Counts set bits of an edge vector
  function automatic logic [CNT_W-1:0] popCount(input logic [NUM_EV-1:0] v);
    logic [CNT_W-1:0] n;
    n = '0;
    for (int i = 0; i < NUM_EV; i++) begin
      n = n + {{(CNT_W-1){1'b0}}, v[i]};
    end
    return n;
  endfunction : popCount

  // Merges write data into a register under byte enables
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wdat,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = wdat[b*8 +: 8];
      end
    end
    return r;
  endfunction : mergeBytes

  // Software settings; none of them is switched with the setting group
  logic [31:0] ctrlReg;
  logic [31:0] zoneCfg;
  logic [15:0] lightEn;
  logic [15:0] presEn;
  logic [NUM_EV-1:0] onSel;
  logic [NUM_EV-1:0] offSel;
  logic [3:0] recSel;

  logic busWrite;
  logic busRead;
  logic clrProt;
  logic clrStart;
  logic clrTrip;
  logic blockSampled;
  logic [NUM_PROT_EV-1:0] protFlags;
  logic [NUM_PROT_EV-1:0] next_protFlags;
  logic [3:0] next_zoneTrip;
  logic [3:0] next_zoneBlocked;
  logic [3:0] pickup;
  logic [NUM_EV-1:0] curFlags;
  logic [NUM_EV-1:0] newFlags;
  logic [NUM_EV-1:0] riseVec;
  logic [NUM_EV-1:0] fallVec;
  cond_t commonCond;
  cond_t next_commonCond;
  logic [CNT_W-1:0] protCount;
  logic [CNT_W-1:0] startCount;
  logic [CNT_W-1:0] tripCount;
  logic recordHit;
  logic [3:0] wrPtr;
  logic [3:0] recCount;
  logic [31:0] readData;

  // Record store, one entry per operation
  logic [TS_W-1:0] recStamp [REC_DEPTH];
  logic [7:0] recEvent [REC_DEPTH];
  logic [7:0] recSensors [REC_DEPTH];
  logic [2:0] recGroup [REC_DEPTH];
  logic [CUR_W-1:0] recCurA [REC_DEPTH];
  logic [CUR_W-1:0] recCurB [REC_DEPTH];
  logic [CUR_W-1:0] recCurC [REC_DEPTH];
  logic [CUR_W-1:0] recCurR [REC_DEPTH];

  // Request taken on the first cycle it is seen; ack marks the answer one cycle on
  assign busWrite = cyc_i & stb_i & we_i & ~ack_o;
  assign busRead = cyc_i & stb_i & ~we_i & ~ack_o;
  assign clrProt = busWrite && adr_i == OFF_CTRL && sel_i[1] && dat_i[CTRL_CLR_PROT];
  assign clrStart = busWrite && adr_i == OFF_CTRL && sel_i[1] && dat_i[CTRL_CLR_START];
  assign clrTrip = busWrite && adr_i == OFF_CTRL && sel_i[1] && dat_i[CTRL_CLR_TRIP];

  // Bus acknowledge, dropped the cycle after it was given
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_o <= 1'b0;
    end else begin
      ack_o <= cyc_i & stb_i & ~ack_o;
    end
  end

  // Setting registers; clear commands are pulses and never stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrlReg <= RST_ZERO;
      zoneCfg <= RST_ZERO;
      lightEn <= RST_ZERO[15:0];
      presEn <= RST_ZERO[15:0];
      onSel <= RST_ZERO[NUM_EV-1:0];
      offSel <= RST_ZERO[NUM_EV-1:0];
      recSel <= RST_ZERO[3:0];
    end else if (busWrite) begin
      case (adr_i)
        OFF_CTRL: ctrlReg <= mergeBytes(ctrlReg, dat_i, sel_i) & 32'h0000_0007;
        OFF_ZONE_CFG: zoneCfg <= mergeBytes(zoneCfg, dat_i, sel_i) & 32'h000f_ffff;
        OFF_LIGHT_EN: lightEn <= 16'(mergeBytes({16'h0000, lightEn}, dat_i, sel_i));
        OFF_PRES_EN: presEn <= 16'(mergeBytes({16'h0000, presEn}, dat_i, sel_i));
        OFF_EV_ON_SEL: onSel <= NUM_EV'(mergeBytes({4'h0, onSel}, dat_i, sel_i));
        OFF_EV_OFF_SEL: offSel <= NUM_EV'(mergeBytes({4'h0, offSel}, dat_i, sel_i));
        OFF_REC_SEL: recSel <= sel_i[0] ? dat_i[3:0] : recSel;
        default: ;
      endcase
    end
  end

  // Zone pick-up from enabled channels, current elements and the digital input
  always_comb begin
    logic anyChan;
    logic curOk;
    logic sensHit;
    logic diHit;
    anyChan = 1'b0;
    curOk = 1'b0;
    sensHit = 1'b0;
    diHit = 1'b0;
    pickup = 4'h0;
    for (int z = 0; z < 4; z++) begin
      sensHit = |(lightIn & lightEn[z*4 +: 4]) | |(pressureIn & presEn[z*4 +: 4]);
      anyChan = |lightIn | |pressureIn;
      // With no current element chosen, light alone trips the zone
      curOk = ~(zoneCfg[ZCFG_PH_EN+z] | zoneCfg[ZCFG_RES_EN+z])
              | (zoneCfg[ZCFG_PH_EN+z] & phCurrPickup)
              | (zoneCfg[ZCFG_RES_EN+z] & resCurrPickup);
      case (zoneCfg[ZCFG_DI_MODE + z*2 +: 2])
        DI_LIGHT_IN: diHit = digitalIn;
        DI_CURRENT_IN: diHit = digitalIn & anyChan;
        default: diHit = 1'b0;
      endcase
      pickup[z] = zoneCfg[ZCFG_ENABLE+z] & ((sensHit & curOk) | diHit);
    end
  end

  // Trip or blocked is decided once at pick-up and held until pick-up drops
  always_comb begin
    next_zoneTrip = zoneTrip;
    next_zoneBlocked = zoneBlocked;
    for (int z = 0; z < 4; z++) begin
      if (!pickup[z]) begin
        next_zoneTrip[z] = 1'b0;
        next_zoneBlocked[z] = 1'b0;
      end else if (!zoneTrip[z] && !zoneBlocked[z]) begin
        next_zoneTrip[z] = ~blockIn;
        next_zoneBlocked[z] = blockIn;
      end
    end
  end

  // Status word as it will stand after this tick
  always_comb begin
    next_protFlags = '0;
    next_protFlags[EV_ZONE_TRIP +: 4] = next_zoneTrip;
    next_protFlags[EV_ZONE_BLK +: 4] = next_zoneBlocked;
    next_protFlags[EV_PH_BLK] = phCurrPickup & blockIn;
    next_protFlags[EV_PH_START] = phCurrPickup & ~blockIn;
    next_protFlags[EV_RES_BLK] = resCurrPickup & blockIn;
    next_protFlags[EV_RES_START] = resCurrPickup & ~blockIn;
    next_protFlags[EV_LIGHT +: 4] = lightIn;
    next_protFlags[EV_PRES +: 4] = pressureIn;
    next_protFlags[EV_DI] = digitalIn;
    next_protFlags[EV_SENS_FAULT +: 4] = sensorFault;
    next_protFlags[EV_IO_FAULT] = ioUnitFault;
  end

  // Common condition: OR of all starts and trips, then the optional force
  always_comb begin
    logic anyStart;
    logic anyTrip;
    anyStart = |protStart | commonStartIn | next_protFlags[EV_PH_START]
               | next_protFlags[EV_RES_START];
    anyTrip = |protTrip | commonTripIn | |next_zoneTrip;
    // No blocking term here; blocked zones simply never raise a trip
    if (anyTrip) begin
      next_commonCond = COND_TRIP;
    end else if (anyStart) begin
      next_commonCond = COND_START;
    end else begin
      next_commonCond = COND_NORMAL;
    end
    if (ctrlReg[CTRL_FORCE_EN]) begin
      case (ctrlReg[CTRL_FORCE_SEL +: 2])
        COND_START: next_commonCond = COND_START;
        COND_TRIP: next_commonCond = COND_TRIP;
        default: ;
      endcase
    end
  end

  assign curFlags = {commonTrip, commonStart, protFlags};
  assign newFlags = {next_commonCond == COND_TRIP, next_commonCond == COND_START, next_protFlags};
  assign riseVec = cycleTick ? (newFlags & ~curFlags) : '0;
  assign fallVec = cycleTick ? (~newFlags & curFlags) : '0;
  assign recordHit = |riseVec[EV_ZONE_TRIP +: 8];

  // Program-cycle state: blocking sample, status flags, common outputs
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockSampled <= 1'b0;
      protFlags <= '0;
      commonCond <= COND_NORMAL;
    end else if (cycleTick) begin
      blockSampled <= blockIn;
      protFlags <= next_protFlags;
      commonCond <= next_commonCond;
    end
  end

  assign zoneTrip = protFlags[EV_ZONE_TRIP +: 4];
  assign zoneBlocked = protFlags[EV_ZONE_BLK +: 4];
  assign commonStart = commonCond == COND_START;
  assign commonTrip = commonCond == COND_TRIP;

  // Event report: selected edges with the tick's time stamp
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eventStrobe <= 1'b0;
      eventOn <= '0;
      eventOff <= '0;
      eventStamp <= '0;
    end else begin
      eventStrobe <= |(riseVec & onSel) | |(fallVec & offSel);
      if (cycleTick) begin
        eventOn <= riseVec & onSel;
        eventOff <= fallVec & offSel;
        eventStamp <= timeStamp;
      end
    end
  end

  // Counters; an event in the clear cycle is kept, not lost
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      protCount <= '0;
      startCount <= '0;
      tripCount <= '0;
    end else begin
      protCount <= (clrProt ? '0 : protCount)
                   + popCount({2'b00, riseVec[NUM_PROT_EV-1:0]});
      startCount <= (clrStart ? '0 : startCount)
                    + {{(CNT_W-1){1'b0}}, riseVec[EV_COM_START]};
      tripCount <= (clrTrip ? '0 : tripCount)
                   + {{(CNT_W-1){1'b0}}, riseVec[EV_COM_TRIP]};
    end
  end

  // Circular record pointer and fill level
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPtr <= '0;
      recCount <= '0;
    end else if (recordHit) begin
      wrPtr <= (wrPtr == LAST_SLOT) ? 4'h0 : wrPtr + 4'h1;
      recCount <= (recCount == DEPTH4) ? recCount : recCount + 4'h1;
    end
  end

  // Record contents; storage needs no reset, the fill level tells valid slots
  always_ff @(posedge sys_clk) begin
    if (recordHit) begin
      recStamp[wrPtr] <= timeStamp;
      recEvent[wrPtr] <= riseVec[EV_ZONE_TRIP +: 8];
      recSensors[wrPtr] <= {pressureIn, lightIn};
      recGroup[wrPtr] <= settingGroup;
      recCurA[wrPtr] <= phaseCurrA;
      recCurB[wrPtr] <= phaseCurrB;
      recCurC[wrPtr] <= phaseCurrC;
      recCurR[wrPtr] <= residualCurr;
    end
  end

  // Read decode; unmapped offsets and slot numbers past the store read as zero
  always_comb begin
    logic slotOk;
    slotOk = recSel < DEPTH4;
    readData = 32'h0000_0000;
    case (adr_i)
      OFF_CTRL: readData = ctrlReg;
      OFF_ZONE_CFG: readData = zoneCfg;
      OFF_LIGHT_EN: readData = {16'h0000, lightEn};
      OFF_PRES_EN: readData = {16'h0000, presEn};
      OFF_EV_ON_SEL: readData = {4'h0, onSel};
      OFF_EV_OFF_SEL: readData = {4'h0, offSel};
      OFF_PROT_COND: readData = {23'h000000, blockSampled, zoneBlocked, zoneTrip};
      OFF_SENSOR_STAT: readData = {14'h0000, protFlags[NUM_PROT_EV-1:EV_PH_BLK]};
      OFF_COMMON_COND: readData = {30'h00000000, commonCond};
      OFF_PROT_COUNT: readData = {16'h0000, protCount};
      OFF_COMMON_COUNT: readData = {tripCount, startCount};
      OFF_REC_SEL: readData = {28'h0000000, recSel};
      OFF_REC_STAT: readData = {20'h00000, wrPtr, 4'h0, recCount};
      OFF_REC_STAMP_LO: readData = slotOk ? recStamp[recSel][31:0] : 32'h0000_0000;
      OFF_REC_STAMP_HI: readData = slotOk ? {16'h0000, recStamp[recSel][TS_W-1:32]} : '0;
      OFF_REC_INFO: readData = slotOk ? {13'h0000, recGroup[recSel], recSensors[recSel],
                                         recEvent[recSel]} : 32'h0000_0000;
      OFF_REC_CUR_AB: readData = slotOk ? {recCurB[recSel], recCurA[recSel]} : '0;
      OFF_REC_CUR_CR: readData = slotOk ? {recCurR[recSel], recCurC[recSel]} : '0;
      default: readData = 32'h0000_0000;
    endcase
  end

  // Read data registered alongside the acknowledge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      dat_o <= 32'h0000_0000;
    end else if (busRead) begin
      dat_o <= readData;
    end
  end

endmodule : trip_block_event_aggregator

//--- tbea_checker.sv
`timescale 1ns/10ps
module tbea_checker
  import tbea_pkg::*;
#(
  parameter int NUM_PROT = 8
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic ack_o,
  input wire logic cycleTick,
  input wire logic [TS_W-1:0] timeStamp,
  input wire logic blockIn,
  input wire logic [NUM_PROT-1:0] protTrip,
  input wire logic commonTripIn,
  input wire logic [3:0] zoneTrip,
  input wire logic [3:0] zoneBlocked,
  input wire logic commonStart,
  input wire logic commonTrip,
  input wire logic eventStrobe,
  input wire logic [NUM_EV-1:0] eventOn,
  input wire logic [NUM_EV-1:0] eventOff,
  input wire logic [TS_W-1:0] eventStamp
);
  // One domain, so clock and reset are stated once
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  // Bus answers in the next cycle, for one cycle only
  a_ack_one_cycle:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o) else $error("bad ack");
  // Zone flags move only at a tick
  a_flags_on_tick:
    assert property (!cycleTick |=> $stable(zoneTrip) && $stable(zoneBlocked))
      else $error("zone flags moved without tick");
  a_trip_or_block:
    assert property ((zoneTrip & zoneBlocked) == 4'h0) else $error("tripped and blocked");
  // The blocking sample decides what a new pick-up becomes
  a_blocked_no_trip:
    assert property (cycleTick && blockIn |=> (zoneTrip & ~$past(zoneTrip)) == 4'h0)
      else $error("trip rose while blocked");
  a_open_no_block:
    assert property (cycleTick && !blockIn |=> (zoneBlocked & ~$past(zoneBlocked)) == 4'h0)
      else $error("blocked rose while open");
  // Force may turn trip into start, so either output is accepted
  a_common_trip:
    assert property (cycleTick && (|protTrip || commonTripIn) |=> commonTrip || commonStart)
      else $error("common trip missing");
  a_zone_common:
    assert property (zoneTrip != 4'h0 |-> commonTrip || commonStart)
      else $error("zone trip not in common");
  a_stamp_of_tick:
    assert property (cycleTick |=> eventStamp == $past(timeStamp)) else $error("wrong stamp");
  a_strobe_cause:
    assert property (eventStrobe |-> $past(cycleTick) && (eventOn | eventOff) != '0)
      else $error("strobe without cause");
  a_trip_on_edge:
    assert property (eventStrobe && eventOn[EV_COM_TRIP] |-> commonTrip && !$past(commonTrip))
      else $error("trip event without edge");
endmodule : tbea_checker

bind trip_block_event_aggregator tbea_checker #(.NUM_PROT(NUM_PROT)) i_chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o),
  .cycleTick(cycleTick), .timeStamp(timeStamp), .blockIn(blockIn), .protTrip(protTrip),
  .commonTripIn(commonTripIn), .zoneTrip(zoneTrip), .zoneBlocked(zoneBlocked),
  .commonStart(commonStart), .commonTrip(commonTrip), .eventStrobe(eventStrobe),
  .eventOn(eventOn), .eventOff(eventOff), .eventStamp(eventStamp));

//--- far_side_model.sv
`timescale 1ns/10ps
module far_side_model
  import tbea_pkg::*;
#(
  parameter int TICK_DIV = 6
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic blockReq,
  output logic cycleTick,
  output logic [TS_W-1:0] timeStamp,
  output logic blockIn
);
  logic [7:0] divCnt;

  // Program cycle runs free; stamp advances one ms per cycle
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divCnt <= 8'h00;
      cycleTick <= 1'b0;
      timeStamp <= '0;
    end else begin
      cycleTick <= (divCnt == 8'(TICK_DIV - 1));
      divCnt <= (divCnt == 8'(TICK_DIV - 1)) ? 8'h00 : divCnt + 8'h01;
      if (cycleTick) begin
        timeStamp <= timeStamp + 1'b1;
      end
    end
  end

  // Blocking matrix passes the request on one clock later, well ahead of the operate delay
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      blockIn <= 1'b0;
    end else begin
      blockIn <= blockReq;
    end
  end
endmodule : far_side_model

//--- trip_block_event_aggregator_tb.sv
`timescale 1ns/10ps
module trip_block_event_aggregator_tb
  import tbea_pkg::*;
;
  logic sys_clk, rst_n, cyc, stb, we, ack, blockReq, cycleTick, blockIn, phPick, resPick;
  logic digIn, ioFault, cStartIn, cTripIn, eStrobe, cStart, cTrip;
  logic [7:0] adr, pStart, pTrip;
  logic [31:0] datW, datR, rng, q;
  logic [3:0] sel, lightIn, presIn, sensFault, zTrip, zBlk;
  logic [CUR_W-1:0] curA, curB, curC, curR;
  logic [2:0] group;
  logic [TS_W-1:0] stamp, eStamp;
  logic [NUM_EV-1:0] evOn, evOff;
  logic [2:0] forceCtl [4] = '{3'h5, 3'h4, 3'h3, 3'h1};
  logic [1:0] forceExp [4] = '{2'h2, 2'h0, 2'h1, 2'h0};
  int nMismatch, samplesChecked, recCnt, nS, nT = 2, pc;

  far_side_model #(.TICK_DIV(6)) i_far (.sys_clk(sys_clk), .rst_n(rst_n),
    .blockReq(blockReq), .cycleTick(cycleTick), .timeStamp(stamp), .blockIn(blockIn));

  trip_block_event_aggregator #(.NUM_PROT(8), .REC_DEPTH(12)) i_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .dat_i(datW), .sel_i(sel), .dat_o(datR), .ack_o(ack), .cycleTick(cycleTick),
    .timeStamp(stamp), .blockIn(blockIn), .phCurrPickup(phPick), .resCurrPickup(resPick),
    .lightIn(lightIn), .pressureIn(presIn), .digitalIn(digIn), .sensorFault(sensFault),
    .ioUnitFault(ioFault), .phaseCurrA(curA), .phaseCurrB(curB), .phaseCurrC(curC),
    .residualCurr(curR), .settingGroup(group), .protStart(pStart), .protTrip(pTrip),
    .commonStartIn(cStartIn), .commonTripIn(cTripIn), .zoneTrip(zTrip),
    .zoneBlocked(zBlk), .commonStart(cStart), .commonTrip(cTrip), .eventStrobe(eStrobe),
    .eventOn(evOn), .eventOff(evOff), .eventStamp(eStamp));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // Trip outranks start in the common condition
  function automatic logic [31:0] exp_cond(input logic [7:0] st, tr, input logic si, ti);
    if (|tr || ti) return 32'h2;
    return (|st || si) ? 32'h1 : 32'h0;
  endfunction : exp_cond

  // Counts common start and trip rises as the expected conditions go by
  task automatic note(input logic [31:0] e);
    nS += int'(e == 1 && pc != 1);
    nT += int'(e == 2 && pc != 2);
    pc = e;
  endtask : note

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samplesChecked, nMismatch);
    if (nMismatch == 0 && samplesChecked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nMismatch++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Classic cycle: hold everything until ack is sampled, then release
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    datW <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1) begin
      nMismatch++;
      tally_and_finish();
    end
    q = datR;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rd

  // Waits for the next program cycle, then samples mid-cycle
  task automatic tick();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (cycleTick !== 1'b1 && n < 50);
    if (cycleTick !== 1'b1) begin
      nMismatch++;
      tally_and_finish();
    end
    @(negedge sys_clk);
  endtask : tick

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask : done

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  initial begin
    {rst_n, cyc, stb, we, blockReq, phPick, resPick, digIn, ioFault, cStartIn, cTripIn} = '0;
    {adr, datW, pStart, pTrip, lightIn, presIn, sensFault, group} = '0;
    {curA, curB, curC, curR} = '0;
    sel = 4'hf;
    rng = 32'h253b;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    rd(OFF_EV_ON_SEL, RST_ZERO);
    rd(OFF_COMMON_COND, RST_ZERO);
    rd(8'h80, RST_ZERO);
    done("reset");
    wb(1'b1, OFF_ZONE_CFG, 32'h8003);
    wb(1'b1, OFF_LIGHT_EN, 32'h1);
    wb(1'b1, OFF_EV_ON_SEL, 32'h0fff_ffff);
    wb(1'b1, OFF_EV_OFF_SEL, 32'h1);
    @(posedge sys_clk);
    lightIn <= 4'h1;
    tick();
    recCnt++;
    chk({28'h0, zTrip}, 32'h1);
    chk(32'(evOn & 28'h1fff), 32'h1001);
    rd(OFF_PROT_COND, 32'h1);
    @(posedge sys_clk);
    lightIn <= 4'h0;
    tick();
    chk({28'h0, zTrip}, 32'h0);
    chk(32'(evOff), 32'h1);
    chk(32'(evOn), 32'h0);
    done("trip");
    // Blocking leads the pick-up by a cycle so the tick sees both
    @(posedge sys_clk);
    blockReq <= 1'b1;
    @(posedge sys_clk);
    lightIn <= 4'h1;
    tick();
    recCnt++;
    chk({24'h0, zBlk, zTrip}, 32'h10);
    rd(OFF_PROT_COND, 32'h110);
    @(posedge sys_clk);
    lightIn <= 4'h2;
    blockReq <= 1'b0;
    tick();
    chk({24'h0, zBlk, zTrip}, 32'h0);
    rd(OFF_PROT_COUNT, 32'h5);
    wb(1'b1, OFF_CTRL, 32'h100);
    rd(OFF_PROT_COUNT, 32'h0);
    done("block");
    @(posedge sys_clk);
    {lightIn, phPick, resPick, digIn, ioFault, presIn, sensFault} <= {4'h0, 4'hf, 8'h35};
    tick();
    recCnt++;
    chk({28'h0, zTrip}, 32'h2);
    rd(OFF_SENSOR_STAT, {14'h0, 1'b1, 4'h5, 1'b1, 4'h3, 8'h0a});
    @(posedge sys_clk);
    {phPick, resPick, digIn, ioFault, presIn, sensFault} <= '0;
    tick();
    rd(OFF_SENSOR_STAT, 32'h0);
    done("sensor");
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      @(posedge sys_clk);
      {pStart, pTrip} <= {rng[7:0], rng[15:8] & rng[23:16]};
      {cStartIn, cTripIn} <= {rng[24], rng[25] & rng[26]};
      tick();
      chk({30'h0, cTrip, cStart}, exp_cond(pStart, pTrip, cStartIn, cTripIn));
      rd(OFF_COMMON_COND, exp_cond(pStart, pTrip, cStartIn, cTripIn));
      note(exp_cond(pStart, pTrip, cStartIn, cTripIn));
    end
    @(posedge sys_clk);
    {pStart, pTrip, cStartIn, cTripIn} <= '0;
    tick();
    note(32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, OFF_CTRL, {29'h0, forceCtl[i]});
      tick();
      chk({30'h0, cTrip, cStart}, {30'h0, forceExp[i]});
      rd(OFF_COMMON_COND, {30'h0, forceExp[i]});
      note({30'h0, forceExp[i]});
    end
    rd(OFF_COMMON_COUNT, {nT[15:0], nS[15:0]});
    wb(1'b1, OFF_CTRL, 32'h600);
    rd(OFF_COMMON_COUNT, 32'h0);
    done("common");
    // Thirteen more records wrap the twelve-slot store
    for (int i = 0; i < 13; i++) begin
      rng = xs(rng);
      @(posedge sys_clk);
      {curA, curB, curC, curR, group} <= {rng, ~rng, rng[2:0]};
      lightIn <= 4'h1;
      tick();
      @(posedge sys_clk);
      lightIn <= 4'h0;
      tick();
    end
    recCnt += 13;
    rd(OFF_REC_STAT, {20'h0, 4'(recCnt % 12), 4'h0, 4'hc});
    wb(1'b1, OFF_REC_SEL, 32'((recCnt - 1) % 12));
    rd(OFF_REC_INFO, {13'h0, group, 16'h0101});
    rd(OFF_REC_CUR_AB, {curB, curA});
    rd(OFF_REC_CUR_CR, {curR, curC});
    done("records");
    @(posedge sys_clk);
    lightIn <= 4'h1;
    tick();
    @(posedge sys_clk);
    rst_n <= 1'b0;
    @(posedge sys_clk);
    chk({24'h0, zBlk, zTrip}, 32'h0);
    rst_n <= 1'b1;
    rd(OFF_REC_STAT, RST_ZERO);
    rd(OFF_PROT_COUNT, RST_ZERO);
    done("rerun reset");
    tally_and_finish();
  end
endmodule : trip_block_event_aggregator_tb
